// ---- dv/smb_host.sv ----
`timescale 1ns/100ps
// ------------------------------------------------
// Bus host that answers the attention line.
// ------------------------------------------------
module smb_host (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic half;
        repeat (4) @(posedge clk_i);
    endtask : half
    task automatic bit_io(input logic b, output logic s);
        half();
        sda_o <= b;
        half();
        scl_o <= 1'h1;
        half();
        half();
        s = sda_line_i;
        scl_o <= 1'h0;
    endtask : bit_io
    task automatic ara(output logic [7:0] rd, output logic ack);
        logic s;
        logic [7:0] a;
        a = {fault_sup_pkg::ARA_ADDR, 1'h1};
        sda_o <= 1'h0;
        half();
        scl_o <= 1'h0;
        for (int i = 7; i >= 0; i--) bit_io(a[i], s);
        bit_io(1'h1, s);
        ack = ~s;
        for (int i = 7; i >= 0; i--) bit_io(1'h1, rd[i]);
        bit_io(1'h1, s);
        half();
        sda_o <= 1'h0;
        half();
        scl_o <= 1'h1;
        half();
        sda_o <= 1'h1;
    endtask : ara
endmodule : smb_host

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import fault_sup_pkg::*;
    logic clk_i = 1'h0, resetn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic wd_service_i = 1'h0, ctrl_pin_i = 1'h1, restart_pin_i = 1'h0, wd_on = 1'h1, ack, err;
    logic pready_o, pslverr_o, alert_o, alert_oe_o, sda_o, sda_oe_o, scl_i, sda_h;
    logic [7:0] paddr_i = 8'h00, ab;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [NCH-1:0] ov_cmp_i = '0, uv_cmp_i = '0, oc_cmp_i = '0, supply_enable_output_o;
    logic [NTS-1:0][15:0] temp_i = '0;
    logic [NSER-1:0] sensor_fail_i = '0;
    int fail_count = 0, total_checks = 0, cyc = 0;
    wire sda_i = sda_h & ~sda_oe_o;
    always #5 clk_i = ~clk_i;
    fault_supervisor_monitor #(.MS_CYC(10), .WD_CYC(200), .POLL_CYC(50)) dut (.clk_i, .resetn_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ov_cmp_i, .uv_cmp_i,
        .oc_cmp_i, .temp_i, .sensor_fail_i, .wd_service_i, .ctrl_pin_i, .restart_pin_i, .scl_i, .sda_i,
        .supply_enable_output_o, .alert_o, .alert_oe_o, .sda_o, .sda_oe_o);
    smb_host host (.clk_i, .sda_line_i(sda_i), .scl_o(scl_i), .sda_o(sda_h));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        wd_service_i <= wd_on && (cyc % 16 == 0);
        if (cyc == 30000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask : xfer
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask : rchk
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rchk(A_CTRL, '1, 32'h1);
        rchk(A_TCFG, '1, 32'h0);
        rchk(A_REACT, '1, 32'hF);
        xfer(1'h0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        xfer(1'h1, 8'h20, 32'h5);
        xfer(1'h1, A_OP, 32'hFF01);
        repeat (4) @(posedge clk_i);
        chk("supply", 32'h1, {27'h0, supply_enable_output_o});
        ov_cmp_i <= 5'h03;
        repeat (4) @(posedge clk_i);
        rchk(A_STATE, 32'h11F, 32'h100);
        rchk(A_STAT, 32'h8000, 32'h8000);
        chk("alert", 32'h1, {30'h0, alert_o, alert_oe_o});
        ov_cmp_i <= 5'h00;
        host.ara(ab, ack);
        chk("ara reply", 32'h1A4, {22'h0, sda_o, ack, ab});
        repeat (4) @(posedge clk_i);
        chk("alert release", 32'h0, {31'h0, alert_oe_o});
        rchk(A_STAT, 32'h8000, 32'h8000);
        xfer(1'h1, A_CTRL, 32'h5);
        rchk(A_STAT, '1, 32'h0);
        xfer(1'h1, A_OP, 32'hFF00);
        xfer(1'h1, A_OP, 32'hFF01);
        repeat (4) @(posedge clk_i);
        rchk(A_STATE, 32'h11F, 32'h1);
        temp_i[4] <= 16'h3E81;
        temp_i[5] <= 16'h0100;
        temp_i[1] <= 16'h0200;
        sensor_fail_i <= 4'h1;
        xfer(1'h1, A_TCFG, 32'h13);
        repeat (120) @(posedge clk_i);
        rchk(8'h60, '1, 32'h7FFF);
        rchk(8'h64, '1, 32'h0200);
        rchk(8'h70, '1, 32'h7FFF);
        rchk(8'h74, '1, 32'h0);
        rchk(A_STAT, 32'h4, 32'h4);
        rchk(A_MFR, '1, 32'h0);
        wd_on <= 1'h0;
        repeat (260) @(posedge clk_i);
        rchk(A_MFR, 32'h1, 32'h1);
        rchk(A_STAT, 32'h1001, 32'h1001);
        restart_pin_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        rchk(A_STAT, '1, 32'h0);
        end_of_test();
    end
endmodule : testbench

// ---- src/fault_sup_pkg.sv ----
package fault_sup_pkg;
    localparam int NCH = 5;
    localparam int NTS = 6;
    localparam int NSER = 4;
    localparam int DIODE = 4;
    localparam int INTERNAL = 5;
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int WD_LIMIT_MS = 500;
    localparam int POLL_MS = 1000;
    localparam int WD_CYCLES = WD_LIMIT_MS * MS_CYCLES;
    localparam int POLL_CYCLES = POLL_MS * MS_CYCLES;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OP = 8'h04;
    localparam logic [7:0] A_STATE = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_MFR = 8'h10;
    localparam logic [7:0] A_TCFG = 8'h18;
    localparam logic [7:0] A_OTLIM = 8'h1C;
    localparam logic [7:0] A_REACT = 8'h38;
    localparam logic [2:0] A_TON = 3'h1;
    localparam logic [2:0] A_OC = 3'h2;
    localparam logic [2:0] A_TEMP = 3'h3;
    localparam int CB_ALERT = 0;
    localparam int CB_GLOBAL = 1;
    localparam int CB_CLEAR = 2;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [5:0] TCFG_RST = 6'h00;
    localparam logic [15:0] OT_RST = 16'h2328;
    localparam logic [3:0] REACT_RST = 4'hF;
    localparam int OP_ON = 0;
    localparam logic [7:0] PAGE_ALL = 8'hFF;
    localparam int RB_OV = 0;
    localparam int RB_UV = 1;
    localparam int RB_OC = 2;
    localparam int RB_TON = 3;
    localparam int SW_NONE = 0;
    localparam int SW_TEMP = 2;
    localparam int SW_MFR = 12;
    localparam int SW_IOUT = 14;
    localparam int SW_VOUT = 15;
    localparam int MFR_WD = 0;
    localparam int F_OV = 0;
    localparam int F_UV = 5;
    localparam int F_OC = 10;
    localparam int F_TON = 15;
    localparam int F_TF = 20;
    localparam int F_OT = 26;
    localparam int F_WD = 32;
    localparam int F_W = 33;
    localparam logic [2:0] AVG_N = 3'h4;
    localparam int AVG_SH = 2;
    localparam logic signed [15:0] T_DIODE_HI = 16'sh3E80;
    localparam logic signed [15:0] T_INT_HI = 16'sh32C8;
    localparam logic signed [15:0] T_LO = 16'shE890;
    localparam logic [15:0] TEMP_FAULT = 16'h7FFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int P_CTRL = 0;
    localparam int P_RST = 1;
    localparam int P_SCL = 2;
    localparam int P_SDA = 3;
    localparam logic [3:0] PIN_RST = 4'hC;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK = 3'b010,
        S_SEND = 3'b011,
        S_MACK = 3'b100
    } smb_st_t;
endpackage : fault_sup_pkg

// ---- src/fault_supervisor_monitor.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// What this block does
// - Voltage codes use unit slope, one count per mV.
// - Voltage values are two bytes, always positive.
// - Faults set status and raise enabled attention.
// - Answer alert address with own address, release.
// - Status clears by command, restart pin, power.
// - Latched supply restarts after off-on or restart.
// - Faults block turn-on; global mode blocks all.
// - Global turn-on powers enabled supplies, reactions follow.
// - Overvoltage watched only for enabled supplies.
// - Undervoltage watched only when on and risen.
// - Overcurrent watched when enabled and limit nonzero.
// - Power-up time checked only during power-on.
// - Overtemperature watched only for enabled sensors.
// - Watchdog unserviced 500 ms resets configuration.
// - Watchdog reset sets none, vendor, watchdog flags.
// - Sensors sampled each second, internal ones averaged.
// - Out-of-range diode or internal reading, or failed serial access, is sensor fault.
// - Sensor fault reads 7FFFh, sets temperature flag.
// - Disabled sensor reads as zero.
// - Six sensors: four serial, diode, internal.
// ----------------------------------------------------------------
module fault_supervisor_monitor #(
    parameter int MS_CYC = fault_sup_pkg::MS_CYCLES,
    parameter int WD_CYC = fault_sup_pkg::WD_CYCLES,
    parameter int POLL_CYC = fault_sup_pkg::POLL_CYCLES,
    // Slave address value is arbitrary.
    parameter logic [6:0] OWN_ADDR = 7'h52
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [fault_sup_pkg::NCH-1:0] ov_cmp_i,
    input wire logic [fault_sup_pkg::NCH-1:0] uv_cmp_i,
    input wire logic [fault_sup_pkg::NCH-1:0] oc_cmp_i,
    input wire logic [fault_sup_pkg::NTS-1:0][15:0] temp_i,
    input wire logic [fault_sup_pkg::NSER-1:0] sensor_fail_i,
    input wire logic wd_service_i,
    input wire logic ctrl_pin_i,
    input wire logic restart_pin_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic [fault_sup_pkg::NCH-1:0] supply_enable_output_o,
    output logic alert_o,
    output logic alert_oe_o,
    output logic sda_o,
    output logic sda_oe_o
);
    import fault_sup_pkg::*;

    logic [1:0] rsync_q;
    logic rstn;
    logic [3:0] ps1_q, ps2_q, pd_q;
    logic [31:0] ms_cnt_q, wd_cnt_q, poll_cnt_q;
    logic ms_tick, poll, wd_fire, rst_tog, acc, wr, do_clr, new_evt;
    logic [2:0] idx;
    logic in_ton, in_oc, in_temp, pg_all;
    logic [1:0] ctrl_q;
    logic [5:0] tcfg_q;
    logic [15:0] otlim_q, sw;
    logic [3:0] react_q;
    logic [NCH-1:0][15:0] ton_q, oc_q, ton_cnt_q;
    logic [NCH-1:0] op_q, op_d, en_q, en_d, latch_q, latch_d, risen_q, sup_en, oc_en;
    logic [NCH-1:0] ov_now, uv_now, oc_now, ton_hit, flt_now, trip, cmd_on, blk;
    logic [F_W-1:0] flags_q, set_all;
    logic [NTS-1:0][15:0] trd_q, new_val;
    logic [NTS-1:0] meas, bad, tf_set, ot_set;
    logic [2:0] avg_cnt_q;
    logic signed [17:0] dacc_q, iacc_q;
    logic avg_done;
    logic [31:0] rdata_d;
    logic err_d, alrt_q, ara_done_q, scl_r, scl_f, smb_start, smb_stop, ara_hit;
    smb_st_t st_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    genvar g;

    function automatic logic out_of_range(input logic signed [15:0] v, input logic signed [15:0] hi);
        return v > hi || v < T_LO;
    endfunction : out_of_range

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rstn = rsync_q[1];

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            ps1_q <= PIN_RST;
            ps2_q <= PIN_RST;
            pd_q <= PIN_RST;
        end else begin
            ps1_q <= {sda_i, scl_i, restart_pin_i, ctrl_pin_i};
            ps2_q <= ps1_q;
            pd_q <= ps2_q;
        end
    end
    assign rst_tog = ps2_q[P_RST] ^ pd_q[P_RST];

    // ------------------------------------------------------------
    // Timebases and watchdog
    // ------------------------------------------------------------
    assign ms_tick = ms_cnt_q == 32'(MS_CYC - 1);
    assign poll = poll_cnt_q == 32'(POLL_CYC - 1);
    assign wd_fire = wd_cnt_q == 32'(WD_CYC - 1);

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            ms_cnt_q <= '0;
            wd_cnt_q <= '0;
            poll_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 32'h1;
            wd_cnt_q <= (wd_service_i || wd_fire) ? '0 : wd_cnt_q + 32'h1;
            poll_cnt_q <= poll ? '0 : poll_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    assign acc = psel_i & penable_i & ~pready_o;
    assign wr = acc & pwrite_i;
    assign idx = paddr_i[4:2];
    assign in_ton = paddr_i[7:5] == A_TON && idx < 3'(NCH);
    assign in_oc = paddr_i[7:5] == A_OC && idx < 3'(NCH);
    assign in_temp = paddr_i[7:5] == A_TEMP && idx < 3'(NTS);
    assign pg_all = pwdata_i[15:8] == PAGE_ALL;
    // clear by command or restart pin
    assign do_clr = (wr && paddr_i == A_CTRL && pwdata_i[CB_CLEAR]) || rst_tog;

    for (g = 0; g < NCH; g++) begin : g_ch
        assign op_d[g] = (pg_all || pwdata_i[15:8] == 8'(g)) ? pwdata_i[OP_ON] : op_q[g];
        assign sup_en[g] = ton_q[g] != ZERO16;
        assign oc_en[g] = oc_q[g] != ZERO16;
        assign ton_hit[g] = sup_en[g] & en_q[g] & ~risen_q[g] & (ton_cnt_q[g] >= ton_q[g]);
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RST;
            op_q <= '0;
            tcfg_q <= TCFG_RST;
            otlim_q <= OT_RST;
            react_q <= REACT_RST;
            ton_q <= '0;
            oc_q <= '0;
        end else if (wd_fire) begin
            ctrl_q <= CTRL_RST;
            op_q <= '0;
            tcfg_q <= TCFG_RST;
            otlim_q <= OT_RST;
            react_q <= REACT_RST;
            ton_q <= '0;
            oc_q <= '0;
        end else if (wr) begin
            if (paddr_i == A_CTRL) ctrl_q <= pwdata_i[1:0];
            if (paddr_i == A_OP) op_q <= op_d;
            if (paddr_i == A_TCFG) tcfg_q <= pwdata_i[5:0];
            if (paddr_i == A_OTLIM) otlim_q <= pwdata_i[15:0];
            if (paddr_i == A_REACT) react_q <= pwdata_i[3:0];
            if (in_ton) ton_q[idx] <= pwdata_i[15:0];
            if (in_oc) oc_q[idx] <= pwdata_i[15:0];
        end
    end

    always_comb begin
        rdata_d = 32'h0;
        err_d = 1'b0;
        case (paddr_i)
            A_CTRL: rdata_d[1:0] = ctrl_q;
            A_OP: rdata_d[NCH-1:0] = op_q;
            A_STATE: rdata_d = {11'h0, risen_q, 3'h0, latch_q, 3'h0, en_q};
            A_STAT: rdata_d[15:0] = sw;
            A_MFR: rdata_d[MFR_WD] = flags_q[F_WD];
            A_TCFG: rdata_d[5:0] = tcfg_q;
            A_OTLIM: rdata_d[15:0] = otlim_q;
            A_REACT: rdata_d[3:0] = react_q;
            default: begin
                // values pass as one-count direct codes
                if (in_ton) begin
                    rdata_d[15:0] = ton_q[idx];
                end else if (in_oc) begin
                    rdata_d[15:0] = oc_q[idx];
                end else if (in_temp) begin
                    rdata_d[15:0] = tcfg_q[idx] ? trd_q[idx] : ZERO16;
                end else begin
                    err_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc & err_d;
            prdata_o <= (acc && !pwrite_i) ? rdata_d : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Supply supervision
    // ------------------------------------------------------------
    // overvoltage needs enabled supply
    assign ov_now = ov_cmp_i & sup_en;
    // undervoltage needs enable output and rise
    assign uv_now = uv_cmp_i & sup_en & en_q & risen_q;
    assign oc_now = oc_cmp_i & sup_en & oc_en;
    assign flt_now = ov_now | uv_now | oc_now | ton_hit;
    assign trip = (ov_now & {NCH{react_q[RB_OV]}}) | (uv_now & {NCH{react_q[RB_UV]}})
        | (oc_now & {NCH{react_q[RB_OC]}}) | (ton_hit & {NCH{react_q[RB_TON]}});
    // operation and control pin both command on
    assign cmd_on = op_q & {NCH{ps2_q[P_CTRL]}};
    // present fault on the supply holds off its turn-on; global mode: any fault holds off all
    assign blk = ctrl_q[CB_GLOBAL] ? {NCH{|flt_now}} : flt_now;
    assign en_d = cmd_on & sup_en & ~latch_d & (en_q | ~blk);
    // latch ends on off command or restart pin
    assign latch_d = trip | (latch_q & cmd_on & ~{NCH{rst_tog}});
    assign supply_enable_output_o = en_q;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            en_q <= '0;
            latch_q <= '0;
            risen_q <= '0;
            ton_cnt_q <= '0;
        end else begin
            en_q <= en_d;
            latch_q <= latch_d;
            risen_q <= en_q & (risen_q | ~uv_cmp_i);
            for (int c = 0; c < NCH; c++) begin
                if (!en_q[c]) begin
                    ton_cnt_q[c] <= ZERO16;
                end else if (ms_tick && !risen_q[c] && ton_cnt_q[c] != TEMP_FAULT) begin
                    ton_cnt_q[c] <= ton_cnt_q[c] + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Temperature sensors
    // ------------------------------------------------------------
    assign avg_done = avg_cnt_q == AVG_N;
    for (g = 0; g < NSER; g++) begin : g_ser
        // serial sensors sampled on each poll
        assign meas[g] = poll & tcfg_q[g];
        assign new_val[g] = temp_i[g];
        assign bad[g] = sensor_fail_i[g];
    end
    assign meas[DIODE] = avg_done & tcfg_q[DIODE];
    assign meas[INTERNAL] = avg_done & tcfg_q[INTERNAL];
    assign new_val[DIODE] = 16'(dacc_q >>> AVG_SH);
    assign new_val[INTERNAL] = 16'(iacc_q >>> AVG_SH);
    assign bad[DIODE] = out_of_range(new_val[DIODE], T_DIODE_HI);
    assign bad[INTERNAL] = out_of_range(new_val[INTERNAL], T_INT_HI);

    for (g = 0; g < NTS; g++) begin : g_ts
        assign tf_set[g] = meas[g] & bad[g];
        assign ot_set[g] = meas[g] & ~bad[g] & ($signed(new_val[g]) > $signed(otlim_q));
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            avg_cnt_q <= 3'h0;
            dacc_q <= '0;
            iacc_q <= '0;
            trd_q <= '0;
        end else begin
            if (poll) begin
                avg_cnt_q <= 3'h1;
                dacc_q <= 18'($signed(temp_i[DIODE]));
                iacc_q <= 18'($signed(temp_i[INTERNAL]));
            end else if (avg_cnt_q != 3'h0 && !avg_done) begin
                avg_cnt_q <= avg_cnt_q + 3'h1;
                dacc_q <= dacc_q + 18'($signed(temp_i[DIODE]));
                iacc_q <= iacc_q + 18'($signed(temp_i[INTERNAL]));
            end else begin
                avg_cnt_q <= 3'h0;
            end
            for (int i = 0; i < NTS; i++) begin
                if (meas[i]) trd_q[i] <= bad[i] ? TEMP_FAULT : new_val[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status and attention line
    // ------------------------------------------------------------
    // watchdog event feeds sticky flags
    assign set_all = {wd_fire, ot_set, tf_set, ton_hit, oc_now, uv_now, ov_now};
    // event is a flag newly set
    assign new_evt = |(set_all & ~flags_q);

    always_comb begin
        sw = 16'h0000;
        sw[SW_NONE] = flags_q[F_WD];
        sw[SW_MFR] = flags_q[F_WD];
        sw[SW_TEMP] = |flags_q[F_TF +: 2 * NTS];
        sw[SW_IOUT] = |flags_q[F_OC +: NCH];
        sw[SW_VOUT] = |flags_q[F_OV +: 2 * NCH] | (|flags_q[F_TON +: NCH]);
    end

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '0;
            alrt_q <= 1'b0;
        end else begin
            // a new event wins over a clear
            flags_q <= set_all | (flags_q & ~{F_W{do_clr}});
            alrt_q <= (new_evt & ctrl_q[CB_ALERT]) | (alrt_q & ~ara_done_q);
        end
    end
    assign alert_oe_o = alrt_q;
    assign alert_o = 1'b0;
    assign sda_o = 1'b0;

    // ------------------------------------------------------------
    // Alert response address answer on the serial bus
    // ------------------------------------------------------------
    assign scl_r = ps2_q[P_SCL] & ~pd_q[P_SCL];
    assign scl_f = ~ps2_q[P_SCL] & pd_q[P_SCL];
    assign smb_start = ps2_q[P_SCL] & pd_q[P_SCL] & pd_q[P_SDA] & ~ps2_q[P_SDA];
    assign smb_stop = ps2_q[P_SCL] & pd_q[P_SCL] & ~pd_q[P_SDA] & ps2_q[P_SDA];
    assign ara_hit = sh_q == {ARA_ADDR, 1'b1} && alrt_q;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            st_q <= S_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
            ara_done_q <= 1'b0;
        end else begin
            ara_done_q <= 1'b0;
            if (smb_start) begin
                st_q <= S_ADDR;
                cnt_q <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (smb_stop) begin
                st_q <= S_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (st_q)
                    S_ADDR: begin
                        if (scl_r) begin
                            sh_q <= {sh_q[6:0], ps2_q[P_SDA]};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_f && cnt_q == BYTE_BITS) begin
                            st_q <= ara_hit ? S_ACK : S_IDLE;
                            sda_oe_o <= ara_hit;
                        end
                    end
                    S_ACK: if (scl_f) begin
                        st_q <= S_SEND;
                        sh_q <= {OWN_ADDR, 1'b0};
                        sda_oe_o <= ~OWN_ADDR[6];
                        cnt_q <= 4'h0;
                    end
                    S_SEND: if (scl_f) begin
                        if (cnt_q == BYTE_BITS - 4'h1) begin
                            st_q <= S_MACK;
                            sda_oe_o <= 1'b0;
                        end else begin
                            sda_oe_o <= ~sh_q[6];
                            sh_q <= {sh_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    // release after the address is sent
                    S_MACK: if (scl_r) begin
                        st_q <= S_IDLE;
                        ara_done_q <= 1'b1;
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn);

    chk_alert_cause: assert property ($rose(alrt_q) |-> $past(new_evt && ctrl_q[CB_ALERT]))
        else $error("Attention rose without an enabled event.");
    chk_alert_hold: assert property (alrt_q && !ara_done_q |=> alrt_q)
        else $error("Attention dropped before it was answered.");
    chk_ara_release: assert property (ara_done_q && !new_evt |=> !alrt_q)
        else $error("Attention not released after answer.");
    chk_clear_flags: assert property (do_clr && set_all == '0 |=> flags_q == '0)
        else $error("Clear left status flags set.");
    chk_latch_stays: assert property (latch_q[0] && cmd_on[0] && !rst_tog |=> latch_q[0] && !en_q[0])
        else $error("Latched supply restarted without off command.");
    chk_block_on: assert property ($rose(en_q[0]) |-> $past(!blk[0] && cmd_on[0] && sup_en[0]))
        else $error("Supply turned on while blocked.");
    chk_ov_gate: assert property (!flags_q[F_OV] && !sup_en[0] |=> !flags_q[F_OV])
        else $error("Overvoltage flagged on a disabled supply.");
    chk_uv_off: assert property (!en_q[0] |=> !risen_q[0] && !flags_q[F_UV] || $past(flags_q[F_UV]))
        else $error("Undervoltage watched while supply off.");
    chk_wd_flags: assert property (wd_fire |=> flags_q[F_WD] && sw[SW_NONE] && ctrl_q == CTRL_RST)
        else $error("Watchdog reset did not set its flags.");
    chk_temp_fault: assert property (tf_set[DIODE] |=> trd_q[DIODE] == TEMP_FAULT && sw[SW_TEMP])
        else $error("Sensor fault not reported as 7FFFh.");

    cov_ara_answer: cover property (ara_done_q);
    cov_wd_reset: cover property (wd_fire);
    cov_supply_on: cover property ($rose(en_q[0]));
    cov_diode_fault: cover property (tf_set[DIODE]);
endmodule : fault_supervisor_monitor
